// file: include/radio_bank_defs.vh
// Address map, field positions and defaults of the radio RAM configuration bank
`ifndef RADIO_BANK_DEFS_VH
`define RADIO_BANK_DEFS_VH
`define ADDR_RADIO_CFG 16'h607E
`define ADDR_END_REASON 16'h607F
`define ADDR_ENTRY_BASE 16'h6018
`define ADDR_ENTRY_LAST 16'h6077
`define ENTRY_BYTES 7'h0C
`define ENTRY_COUNT 8
`define ENTRY_MEM_DEPTH 96
`define ADDR_P5_FREQEST 16'h6006
`define ADDR_P5_RSSI_LO 16'h6008
`define ADDR_P5_RSSI_HI 16'h6009
`define ADDR_P5_RSSI_DIFF 16'h600A
`define ADDR_P5_LNA_SAT 16'h600B
`define ADDR_P5_TONE_DUR_L 16'h600C
`define ADDR_P5_TONE_DUR_H 16'h600D
`define ADDR_P5_TONE_RED_L 16'h600E
`define ADDR_P5_TONE_RED_H 16'h600F
`define IDX_SETTINGS 7'h00
`define IDX_MAX_RX_LEN 7'h01
`define IDX_ADDRESS 7'h02
`define IDX_ORDER_STATE 7'h03
`define IDX_REPLY0_SIZE 7'h04
`define IDX_REPLY1_SIZE 7'h05
`define IDX_CHECK_LO 7'h06
`define IDX_CHECK_HI 7'h07
`define IDX_SENT_CNT 7'h08
`define IDX_REPEAT_CNT 7'h09
`define IDX_GOOD_CNT 7'h0A
`define IDX_BAD_CNT 7'h0B
`define BIT_PRIMARY_SYNC 0
`define BIT_SECONDARY_SYNC 1
`define BIT_KEEP_REPLY 2
`define BIT_AUTO_ACK 3
`define BIT_VAR_LEN 4
`define BIT_FIFO_TAG 5
`define BIT_FIXED_LEN 6
`define BIT_STATE_VALID 0
`define BIT_PAYLOAD_SENT 5
`define BIT_NEXT_REPLY 6
`define DEF_RSSI_LO 8'h20
`define DEF_RSSI_HI 8'h3C
`define DEF_RSSI_DIFF 8'h14
`define DEF_LNA_SAT 8'h4A
`define DEF_TONE_DUR 16'h064A
`define DEF_TONE_RED 16'h0600
`define AUTO_LEN_MASK 8'h7F
`define INIT_CYCLES 3'h4
`define ZERO8 8'h00
`endif

// file: src/radio_ram_config_bank.v
// Radio RAM configuration and status bank shared by host and link engine
// Summary of operation
// - Receive timestamp select from config bits 1:0
// - Transmit timestamp select from config bits 3:2
// - Bits 5:4 give 2 Mbps transmit IF
// - Bit 6 selects special offset routine
// - Bit 7 enables offset write-back on good CRC
// - Entry bits 0,1 enable primary/secondary sync
// - Entry bit 3 enables auto ack/retransmit
// - Entry bit 4 selects variable receive length
// - Entry bit 5 takes order tag from FIFO
// - Entry bit 6 selects fixed length transmit
// - Size limit 0-127 auto, 0-255 basic
// - Valid flag gates duplicate packet rejection
// - Order state holds packet and reply tags
// - Order state records payload sent, next buffer
// - Reply size zero means free; engine frees
// - Host writes a size only while it is zero, engine clears nonzero
// - Keep last two bytes of received check
// - Sent counter counts confirmed new packets
// - Repeat, good and bad receive counters
// - Engine loads AGC defaults after enable
// - Engine loads tone duration and reduction defaults
`timescale 1ns/1ps
`include "radio_bank_defs.vh"

module radio_ram_config_bank
(
    input wire core_clk,
    input wire arst_n,
    input wire [15:0] host_addr,
    input wire [7:0] host_wdata,
    input wire host_wr,
    input wire host_rd,
    input wire radio_ram_page_select,
    output reg [7:0] host_rdata_r,
    input wire link_engine_enable,
    output reg link_engine_idle_r,
    input wire [2:0] entry_sel,
    input wire auto_mode,
    input wire [1:0] cand_order_tag,
    input wire [15:0] cand_check,
    input wire ev_rx_new_ok,
    input wire ev_rx_repeat,
    input wire ev_rx_crc_err,
    input wire ev_reply_sent,
    input wire ev_reply_with_payload,
    input wire ev_tx_acked,
    input wire ev_rx_end,
    input wire [7:0] rx_freq_est,
    input wire ev_task_end,
    input wire [7:0] end_reason,
    output reg [1:0] receive_timestamp_select_r,
    output reg [1:0] transmit_timestamp_select_r,
    output reg [1:0] transmit_if_offset_r,
    output reg special_offset_routine_r,
    output reg offset_writeback_enable_r,
    output reg primary_sync_enable_r,
    output reg secondary_sync_enable_r,
    output reg auto_ack_retransmit_enable_r,
    output reg variable_length_enable_r,
    output reg fifo_sourced_order_tag_r,
    output reg fixed_length_transmit_r,
    output reg [7:0] receive_size_limit_r,
    output reg [1:0] packet_order_tag_r,
    output reg [1:0] reply_order_tag_r,
    output reg [7:0] reply_size_r,
    output reg packet_is_new_r,
    output reg [7:0] rssi_lower_r,
    output reg [7:0] rssi_upper_r,
    output reg [7:0] rssi_gain_diff_r,
    output reg [7:0] lna_sat_gain_r,
    output reg [15:0] tone_duration_r,
    output reg [15:0] tone_cal_reduction_r
);

    reg [7:0] entry_mem [0:`ENTRY_MEM_DEPTH-1];
    reg [7:0] radio_cfg_r;
    reg [7:0] end_reason_r;
    reg [7:0] freq_est_r;
    reg [2:0] init_cnt_r;
    integer i;
    integer k;

    wire [15:0] host_off_full = host_addr - `ADDR_ENTRY_BASE;
    wire [6:0] host_off = host_off_full[6:0];
    wire host_in_entry = (host_addr >= `ADDR_ENTRY_BASE) && (host_addr <= `ADDR_ENTRY_LAST);
    wire [6:0] sel_base = {1'b0, entry_sel, 3'b000} + {2'b00, entry_sel, 2'b00};
    wire [7:0] sel_settings = entry_mem[sel_base + `IDX_SETTINGS];
    wire [7:0] sel_state = entry_mem[sel_base + `IDX_ORDER_STATE];
    wire [7:0] sel_max_len = entry_mem[sel_base + `IDX_MAX_RX_LEN];
    wire [6:0] idx_state = sel_base + `IDX_ORDER_STATE;
    wire [6:0] idx_r0 = sel_base + `IDX_REPLY0_SIZE;
    wire [6:0] idx_r1 = sel_base + `IDX_REPLY1_SIZE;
    wire [6:0] idx_cur_reply = sel_state[`BIT_NEXT_REPLY] ? idx_r1 : idx_r0;
    wire [6:0] idx_prev_reply = sel_state[`BIT_NEXT_REPLY] ? idx_r0 : idx_r1;
    wire [6:0] idx_chk_lo = sel_base + `IDX_CHECK_LO;
    wire [6:0] idx_chk_hi = sel_base + `IDX_CHECK_HI;
    wire [6:0] idx_sent = sel_base + `IDX_SENT_CNT;
    wire [6:0] idx_rep = sel_base + `IDX_REPEAT_CNT;
    wire [6:0] idx_good = sel_base + `IDX_GOOD_CNT;
    wire [6:0] idx_bad = sel_base + `IDX_BAD_CNT;
    wire [15:0] stored_check = {entry_mem[idx_chk_hi], entry_mem[idx_chk_lo]};
    wire init_active = link_engine_enable && !link_engine_idle_r;
    wire host_p5 = radio_ram_page_select;
    wire [1:0] next_pkt_tag = sel_state[2:1] + 2'b01;
    wire [1:0] next_reply_tag = sel_state[4:3] + 2'b01;
    wire freeing = sel_state[`BIT_PAYLOAD_SENT] && !sel_settings[`BIT_KEEP_REPLY]
        && (entry_mem[idx_prev_reply] != `ZERO8);

    // Byte inside the addressed entry; entries are twelve bytes, so no bit slice will do
    reg [6:0] host_byte;
    reg [6:0] entry_floor;
    always @*
    begin
        host_byte = host_off;
        entry_floor = 7'h00;
        for (k = 0; k < `ENTRY_COUNT; k = k + 1)
        begin
            if (host_off >= entry_floor)
            begin
                host_byte = host_off - entry_floor;
            end
            entry_floor = entry_floor + `ENTRY_BYTES;
        end
    end

    // Host write to a reply size is dropped while the buffer is still owned
    wire host_reply_idx = (host_byte == `IDX_REPLY0_SIZE)
        || (host_byte == `IDX_REPLY1_SIZE);

    // Entry storage: host writes first so engine updates win a same-cycle clash
    always @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            for (i = 0; i < `ENTRY_MEM_DEPTH; i = i + 1)
                entry_mem[i] <= `ZERO8;
        end
        else
        begin
            if (host_wr && host_in_entry)
            begin
                if (!(host_reply_idx && entry_mem[host_off] != `ZERO8))
                    entry_mem[host_off] <= host_wdata;
            end
            if (ev_rx_new_ok)
            begin
                // Valid set, tag stored, payload flag consumed
                entry_mem[idx_state] <= {sel_state[7:6], 1'b0, sel_state[4:3],
                    cand_order_tag, 1'b1};
                entry_mem[idx_chk_lo] <= cand_check[7:0];
                entry_mem[idx_chk_hi] <= cand_check[15:8];
                entry_mem[idx_good] <= entry_mem[idx_good] + 8'h01;
                if (freeing)
                    entry_mem[idx_prev_reply] <= `ZERO8;
                if (sel_state[`BIT_PAYLOAD_SENT])
                    entry_mem[idx_sent] <= entry_mem[idx_sent] + 8'h01;
            end
            else if (ev_reply_sent)
            begin
                // Flip buffer only when a payload went out
                entry_mem[idx_state] <= {sel_state[7],
                    sel_state[`BIT_NEXT_REPLY] ^ ev_reply_with_payload,
                    ev_reply_with_payload, next_reply_tag,
                    sel_state[2:0]};
            end
            else if (ev_tx_acked)
            begin
                entry_mem[idx_sent] <= entry_mem[idx_sent] + 8'h01;
                if (!sel_settings[`BIT_FIFO_TAG])
                    entry_mem[idx_state] <= {sel_state[7:3], next_pkt_tag,
                        sel_state[0]};
            end
            if (ev_rx_repeat)
                entry_mem[idx_rep] <= entry_mem[idx_rep] + 8'h01;
            if (ev_rx_crc_err)
                entry_mem[idx_bad] <= entry_mem[idx_bad] + 8'h01;
        end
    end

    // Page-5 variables and shared bytes; engine init overrides host
    always @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            radio_cfg_r <= `ZERO8;
            end_reason_r <= `ZERO8;
            freq_est_r <= `ZERO8;
            rssi_lower_r <= `ZERO8;
            rssi_upper_r <= `ZERO8;
            rssi_gain_diff_r <= `ZERO8;
            lna_sat_gain_r <= `ZERO8;
            tone_duration_r <= 16'h0000;
            tone_cal_reduction_r <= 16'h0000;
        end
        else
        begin
            if (host_wr)
            begin
                if (host_addr == `ADDR_RADIO_CFG)
                    radio_cfg_r <= host_wdata;
                if (host_p5)
                begin
                    case (host_addr)
                        `ADDR_P5_RSSI_LO: rssi_lower_r <= host_wdata;
                        `ADDR_P5_RSSI_HI: rssi_upper_r <= host_wdata;
                        `ADDR_P5_RSSI_DIFF: rssi_gain_diff_r <= host_wdata;
                        `ADDR_P5_LNA_SAT: lna_sat_gain_r <= host_wdata;
                        `ADDR_P5_TONE_DUR_L: tone_duration_r[7:0] <= host_wdata;
                        `ADDR_P5_TONE_DUR_H: tone_duration_r[15:8] <= host_wdata;
                        `ADDR_P5_TONE_RED_L: tone_cal_reduction_r[7:0] <= host_wdata;
                        `ADDR_P5_TONE_RED_H: tone_cal_reduction_r[15:8] <= host_wdata;
                        default: ;
                    endcase
                end
            end
            if (init_active)
            begin
                rssi_lower_r <= `DEF_RSSI_LO;
                rssi_upper_r <= `DEF_RSSI_HI;
                rssi_gain_diff_r <= `DEF_RSSI_DIFF;
                lna_sat_gain_r <= `DEF_LNA_SAT;
                tone_duration_r <= `DEF_TONE_DUR;
                tone_cal_reduction_r <= `DEF_TONE_RED;
            end
            if (ev_task_end)
                end_reason_r <= end_reason;
            if (ev_rx_end)
                freq_est_r <= rx_freq_est;
        end
    end

    // Engine start-up: idle only rises once defaults are in place
    always @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            init_cnt_r <= 3'h0;
            link_engine_idle_r <= 1'b0;
        end
        else
        begin
            if (!link_engine_enable)
            begin
                init_cnt_r <= 3'h0;
                link_engine_idle_r <= 1'b0;
            end
            else if (!link_engine_idle_r)
            begin
                init_cnt_r <= init_cnt_r + 3'h1;
                if (init_cnt_r == `INIT_CYCLES - 3'h1)
                    link_engine_idle_r <= 1'b1;
            end
        end
    end

    // Registered read port, one cycle latency; unmapped reads give zero
    always @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            host_rdata_r <= `ZERO8;
        else if (host_rd)
        begin
            if (host_in_entry)
                host_rdata_r <= entry_mem[host_off];
            else if (host_addr == `ADDR_RADIO_CFG)
                host_rdata_r <= radio_cfg_r;
            else if (host_addr == `ADDR_END_REASON)
                host_rdata_r <= end_reason_r;
            else if (host_p5)
            begin
                case (host_addr)
                    `ADDR_P5_FREQEST: host_rdata_r <= freq_est_r;
                    `ADDR_P5_RSSI_LO: host_rdata_r <= rssi_lower_r;
                    `ADDR_P5_RSSI_HI: host_rdata_r <= rssi_upper_r;
                    `ADDR_P5_RSSI_DIFF: host_rdata_r <= rssi_gain_diff_r;
                    `ADDR_P5_LNA_SAT: host_rdata_r <= lna_sat_gain_r;
                    `ADDR_P5_TONE_DUR_L: host_rdata_r <= tone_duration_r[7:0];
                    `ADDR_P5_TONE_DUR_H: host_rdata_r <= tone_duration_r[15:8];
                    `ADDR_P5_TONE_RED_L: host_rdata_r <= tone_cal_reduction_r[7:0];
                    `ADDR_P5_TONE_RED_H: host_rdata_r <= tone_cal_reduction_r[15:8];
                    default: host_rdata_r <= `ZERO8;
                endcase
            end
            else
                host_rdata_r <= `ZERO8;
        end
    end

    // Decoded fields toward the engine, one cycle behind the storage
    always @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            receive_timestamp_select_r <= 2'b00;
            transmit_timestamp_select_r <= 2'b00;
            transmit_if_offset_r <= 2'b00;
            special_offset_routine_r <= 1'b0;
            offset_writeback_enable_r <= 1'b0;
            primary_sync_enable_r <= 1'b0;
            secondary_sync_enable_r <= 1'b0;
            auto_ack_retransmit_enable_r <= 1'b0;
            variable_length_enable_r <= 1'b0;
            fifo_sourced_order_tag_r <= 1'b0;
            fixed_length_transmit_r <= 1'b0;
            receive_size_limit_r <= `ZERO8;
            packet_order_tag_r <= 2'b00;
            reply_order_tag_r <= 2'b00;
            reply_size_r <= `ZERO8;
            packet_is_new_r <= 1'b0;
        end
        else
        begin
            receive_timestamp_select_r <= radio_cfg_r[1:0];
            transmit_timestamp_select_r <= radio_cfg_r[3:2];
            transmit_if_offset_r <= radio_cfg_r[5:4];
            special_offset_routine_r <= radio_cfg_r[6];
            offset_writeback_enable_r <= radio_cfg_r[7];
            primary_sync_enable_r <= sel_settings[`BIT_PRIMARY_SYNC];
            secondary_sync_enable_r <= sel_settings[`BIT_SECONDARY_SYNC];
            auto_ack_retransmit_enable_r <= sel_settings[`BIT_AUTO_ACK];
            variable_length_enable_r <= sel_settings[`BIT_VAR_LEN];
            fifo_sourced_order_tag_r <= sel_settings[`BIT_FIFO_TAG];
            fixed_length_transmit_r <= sel_settings[`BIT_FIXED_LEN];
            // Top bit dropped in auto mode, full byte in basic mode
            receive_size_limit_r <= auto_mode ? (sel_max_len & `AUTO_LEN_MASK)
                : sel_max_len;
            packet_order_tag_r <= sel_state[2:1];
            reply_order_tag_r <= sel_state[4:3];
            reply_size_r <= entry_mem[idx_cur_reply];
            // Duplicate only if tag and check both match a valid state
            packet_is_new_r <= !sel_state[`BIT_STATE_VALID]
                || (cand_order_tag != sel_state[2:1])
                || (cand_check != stored_check);
        end
    end

endmodule

// file: verif/host_engine_model.sv
// Host firmware and link engine stand-in: bus cycles and engine event pulses
`timescale 1ns/1ps
module host_engine_model
(
    input wire core_clk,
    output logic [15:0] host_addr = 16'h0000,
    output logic [7:0] host_wdata = 8'h00,
    output logic host_wr = 1'b0,
    output logic host_rd = 1'b0,
    output logic [6:0] ev = 7'h00,
    output logic pay = 1'b0
);
    // Released bus shows inverted values so stale data is never mistaken for live
    task wr(input logic [15:0] a, input logic [7:0] d);
    begin
        @(negedge core_clk);
        host_addr = a;
        host_wdata = d;
        host_wr = 1'b1;
        @(negedge core_clk);
        host_wr = 1'b0;
        host_addr = ~a;
        host_wdata = ~d;
    end
    endtask
    task rd(input logic [15:0] a);
    begin
        @(negedge core_clk);
        host_addr = a;
        host_rd = 1'b1;
        @(negedge core_clk);
        host_rd = 1'b0;
        host_addr = ~a;
    end
    endtask
    // One event class per cycle keeps the engine priority out of play
    task fire(input logic [2:0] c, input logic p);
    begin
        @(negedge core_clk);
        ev = 7'h01 << c;
        pay = p;
        @(negedge core_clk);
        ev = 7'h00;
        pay = 1'b0;
    end
    endtask
endmodule

// file: verif/radio_bank_properties.sv
// Concurrent checks on the ports of the radio RAM configuration bank
`timescale 1ns/1ps
module radio_bank_properties
(
    input wire core_clk, arst_n, host_wr, host_rd, radio_ram_page_select,
    input wire [15:0] host_addr, cand_check,
    input wire [7:0] host_wdata, host_rdata_r, receive_size_limit_r,
    input wire link_engine_enable, link_engine_idle_r, auto_mode, packet_is_new_r,
    input wire [2:0] entry_sel,
    input wire [1:0] cand_order_tag, packet_order_tag_r, reply_order_tag_r,
    input wire ev_rx_new_ok, ev_reply_sent, ev_tx_acked,
    input wire [1:0] receive_timestamp_select_r, transmit_timestamp_select_r,
    input wire [1:0] transmit_if_offset_r,
    input wire special_offset_routine_r, offset_writeback_enable_r,
    input wire [7:0] rssi_lower_r, rssi_upper_r, rssi_gain_diff_r,
    input wire [15:0] tone_duration_r, tone_cal_reduction_r
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    // No event or write that could move the selected entry's order state
    wire quiet = !(ev_rx_new_ok || ev_reply_sent || ev_tx_acked || host_wr);
    a_cfg_decode: assert property (host_wr && host_addr == 16'h607E ##1 !host_wr [*3] |->
        {offset_writeback_enable_r, special_offset_routine_r, transmit_if_offset_r,
        transmit_timestamp_select_r, receive_timestamp_select_r} == $past(host_wdata, 3))
        else $error("config fields differ from written byte");
    a_size_mask: assert property (auto_mode [*3] |-> !receive_size_limit_r[7])
        else $error("size limit above 127 in auto mode");
    a_idle_wait: assert property ($rose(link_engine_enable) |-> !link_engine_idle_r [*3])
        else $error("idle raised before defaults loaded");
    a_idle_drop: assert property (!link_engine_enable |=> !link_engine_idle_r)
        else $error("idle stays high with engine held off");
    a_agc_defaults: assert property ($rose(link_engine_idle_r) |-> rssi_lower_r == 8'h20 &&
        rssi_upper_r == 8'h3C && rssi_gain_diff_r == 8'h14) else $error("agc defaults missing");
    a_tone_defaults: assert property ($rose(link_engine_idle_r) |-> tone_duration_r == 16'h064A
        && tone_cal_reduction_r == 16'h0600) else $error("tone defaults missing");
    a_unmapped_zero: assert property (host_rd && host_addr < 16'h6018 && !radio_ram_page_select
        |=> host_rdata_r == 8'h00) else $error("unmapped read not zero");
    a_rdata_hold: assert property (!host_rd |=> $stable(host_rdata_r))
        else $error("read data moved without a read");
    a_new_stored: assert property (ev_rx_new_ok ##1
        (quiet && $stable({entry_sel, cand_order_tag, cand_check})) [*2] |->
        !packet_is_new_r && packet_order_tag_r == $past(cand_order_tag, 2))
        else $error("stored packet still seen as new");
    a_reply_advance: assert property ((quiet && $stable(entry_sel)) [*2] ##1
        ev_reply_sent && !ev_rx_new_ok ##1 (quiet && $stable(entry_sel)) [*2] |->
        reply_order_tag_r == $past(reply_order_tag_r, 2) + 2'h1) else $error("reply tag stuck");
    cover property (ev_rx_new_ok);
    cover property ($rose(link_engine_idle_r));
    cover property (host_wr && host_addr == 16'h601C);
endmodule
bind radio_ram_config_bank radio_bank_properties radio_bank_properties_i (.*);

// file: verif/tb_radio_ram_config_bank.sv
// Self-checking bench for the radio RAM configuration bank
`timescale 1ns/1ps
module tb_radio_ram_config_bank;
    logic core_clk = 0, arst_n = 0, radio_ram_page_select = 0, link_engine_enable = 0;
    logic auto_mode = 0, pay, host_wr, host_rd, link_engine_idle_r, packet_is_new_r;
    logic [2:0] entry_sel = 3'h0;
    logic [1:0] cand_order_tag = 2'h0;
    logic [15:0] cand_check = 16'h0000, host_addr, tone_duration_r, tone_cal_reduction_r;
    logic [7:0] rx_freq_est = 8'h00, end_reason = 8'h00, host_wdata, host_rdata_r, reply_size_r;
    logic [7:0] receive_size_limit_r, rssi_lower_r, rssi_upper_r, rssi_gain_diff_r, lna_sat_gain_r;
    logic [6:0] ev;
    logic [5:0] entry_bits;
    int err_count = 0, samples_checked = 0, n;
    logic [32:0] rows [10];
    always #50 core_clk = ~core_clk;
    host_engine_model host_engine_model_i (.core_clk, .host_addr, .host_wdata, .host_wr,
        .host_rd, .ev, .pay);
    radio_ram_config_bank radio_ram_config_bank_i (.core_clk, .arst_n, .host_addr, .host_wdata,
        .host_wr, .host_rd, .radio_ram_page_select, .host_rdata_r, .link_engine_enable,
        .link_engine_idle_r, .entry_sel, .auto_mode, .cand_order_tag, .cand_check,
        .ev_rx_new_ok(ev[0]), .ev_rx_repeat(ev[1]), .ev_rx_crc_err(ev[2]), .ev_reply_sent(ev[3]),
        .ev_reply_with_payload(pay), .ev_tx_acked(ev[4]), .ev_rx_end(ev[5]), .rx_freq_est,
        .ev_task_end(ev[6]), .end_reason, .receive_timestamp_select_r(),
        .transmit_timestamp_select_r(), .transmit_if_offset_r(), .special_offset_routine_r(),
        .offset_writeback_enable_r(), .primary_sync_enable_r(entry_bits[0]),
        .secondary_sync_enable_r(entry_bits[1]), .auto_ack_retransmit_enable_r(entry_bits[2]),
        .variable_length_enable_r(entry_bits[3]), .fifo_sourced_order_tag_r(entry_bits[4]),
        .fixed_length_transmit_r(entry_bits[5]), .receive_size_limit_r,
        .packet_order_tag_r(), .reply_order_tag_r(), .reply_size_r, .packet_is_new_r,
        .rssi_lower_r, .rssi_upper_r, .rssi_gain_diff_r, .lna_sat_gain_r, .tone_duration_r,
        .tone_cal_reduction_r);
    task chk(input logic [15:0] seen, input logic [15:0] exp);
    begin
        samples_checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    end
    endtask
    task rdc(input logic [15:0] a, input logic [7:0] exp);
    begin
        host_engine_model_i.rd(a);
        chk({8'h00, host_rdata_r}, {8'h00, exp});
    end
    endtask
    // Bounded wait: idle must come within a few cycles of enable
    task wait_idle;
    begin
        link_engine_enable = 1'b1;
        n = 0;
        while (link_engine_idle_r !== 1'b1 && n < 20)
        begin
            @(negedge core_clk);
            n++;
        end
        chk({15'h0000, link_engine_idle_r}, 16'h0001);
    end
    endtask
    task give_verdict;
    begin
        $display("comparisons %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    end
    endtask
    initial
    begin
        repeat (3000) @(posedge core_clk);
        err_count++;
        give_verdict;
    end
    initial
    begin
        // Page bit, address, write byte, expected read
        rows = '{33'h0_607E_A5A5, 33'h0_6018_6B6B, 33'h0_6019_FFFF, 33'h0_606E_3C3C,
            33'h0_6020_0505, 33'h0_607F_FF00, 33'h0_0000_1200, 33'h1_6008_3333,
            33'h1_6006_7700, 33'h0_6008_5500};
        repeat (8) @(negedge core_clk);
        arst_n = 1'b1;
        rdc(16'h607E, 8'h00);
        chk({8'h00, rssi_lower_r}, 16'h0000);
        $display("reset test done");
        wait_idle;
        chk({rssi_upper_r, rssi_gain_diff_r}, 16'h3C14);
        chk(tone_cal_reduction_r, 16'h0600);
        chk({8'h00, lna_sat_gain_r}, 16'h004A);
        radio_ram_page_select = 1'b1;
        rdc(16'h600C, 8'h4A);
        rdc(16'h600D, 8'h06);
        $display("defaults test done");
        // Host touches page five only after idle, engine never holds the lock here
        foreach (rows[i])
        begin
            radio_ram_page_select = rows[i][32];
            host_engine_model_i.wr(rows[i][31:16], rows[i][15:8]);
            rdc(rows[i][31:16], rows[i][7:0]);
        end
        $display("register rows done");
        chk({10'h000, entry_bits}, 16'h0037);
        auto_mode = 1'b1;
        repeat (3) @(negedge core_clk);
        chk({8'h00, receive_size_limit_r}, 16'h007F);
        auto_mode = 1'b0;
        repeat (3) @(negedge core_clk);
        chk({8'h00, receive_size_limit_r}, 16'h00FF);
        host_engine_model_i.wr(16'h601C, 8'h10);
        host_engine_model_i.wr(16'h601C, 8'h20);
        rdc(16'h601C, 8'h10);
        host_engine_model_i.wr(16'h6028, 8'h11);
        host_engine_model_i.wr(16'h6028, 8'h22);
        rdc(16'h6028, 8'h11);
        chk({8'h00, reply_size_r}, 16'h0010);
        host_engine_model_i.fire(3'h3, 1'b1);
        repeat (2) @(negedge core_clk);
        cand_order_tag = 2'h2;
        cand_check = 16'hBEEF;
        host_engine_model_i.fire(3'h0, 1'b0);
        repeat (2) @(negedge core_clk);
        chk({15'h0000, packet_is_new_r}, 16'h0000);
        rdc(16'h601C, 8'h00);
        rdc(16'h6020, 8'h06);
        rdc(16'h6022, 8'h01);
        rdc(16'h601E, 8'hEF);
        rdc(16'h601F, 8'hBE);
        rdc(16'h601B, 8'h4D);
        cand_order_tag = 2'h3;
        repeat (2) @(negedge core_clk);
        chk({15'h0000, packet_is_new_r}, 16'h0001);
        $display("reply buffer test done");
        host_engine_model_i.fire(3'h1, 1'b0);
        host_engine_model_i.fire(3'h2, 1'b0);
        rdc(16'h6021, 8'h01);
        rdc(16'h6023, 8'h01);
        host_engine_model_i.fire(3'h4, 1'b0);
        rdc(16'h6020, 8'h07);
        rdc(16'h601B, 8'h4D);
        host_engine_model_i.wr(16'h6018, 8'h14);
        host_engine_model_i.fire(3'h4, 1'b0);
        rdc(16'h601B, 8'h4F);
        chk({10'h000, entry_bits}, 16'h0008);
        end_reason = 8'h5A;
        rx_freq_est = 8'h77;
        host_engine_model_i.fire(3'h6, 1'b0);
        host_engine_model_i.fire(3'h5, 1'b0);
        rdc(16'h607F, 8'h5A);
        radio_ram_page_select = 1'b1;
        rdc(16'h6006, 8'h77);
        $display("counter test done");
        // Engine restart wipes the host's page five change
        link_engine_enable = 1'b0;
        repeat (2) @(negedge core_clk);
        chk({8'h00, rssi_lower_r}, 16'h0033);
        wait_idle;
        chk({8'h00, rssi_lower_r}, 16'h0020);
        $display("restart test done");
        give_verdict;
    end
endmodule
